// ===== core/mbfu_core.v
// Purpose: Block-operation unit of a memory card, register side and
//    iteration sequencer
// Assumes: One card clock, requests arrive as one-cycle pulses
// Notes: Registers are reached through the card's uncached access port
//
// What this block does
// - Runs one or two block operations over up to 256 lines, optional irq.
// - Only a control register write starts a function.
// - Advances between lines only when idle controller or 8 commands served.
// - Lock read at 0x800 takes a free lock, returns status word.
// - Status bits 39..36 and 47..40 show lock owner identity.
// - Lock clears when the function's iterations complete, nothing else.
// - Control write accepted only while locked; writer not checked.
// - Phases 0,1 iterate, 2 completion irq, 3 error/monitor irq; 49..48.
// - Start phase field 26..24 picks entry phase, 0 or 1 only.
// - Counts in bits 7..0 and 15..8 up to 0xFF; zero runs 256 iterations.
// - Bits 23..16 give response select attached to issued transactions.
// - Control holds command one in 43..32, command two in 59..48.
// - Phase 0 second part: increment, zero, value and command selects.
// - Phase 1 second part: bit 60 increments, bit 61 zeroes.
// - Status shows module size, line size and card count minus one.
// - Status flags pending, error pending, error, enabled, function irq.
// - Status shows unit revision, board revision, station address.
// - Error captures command in 62..51, address and vector registers.
// - Completion and monitor targets with vectors are read/write.
// - With several cards the line address LSB picks the card.
// - Each iteration issues a command part then a second part.
// - First-part address advances one line per iteration.
// - Phase 0 count done leads to phase 1.
// - Phase 2 sends completion vector to programmed target.
`timescale 1ns/1ps
`include "mbfu_regs.vh"

module mbfu_core #(
   parameter [1:0] MODULE_SIZE = 2'h0,
   parameter [0:0] LINE_SIZE = 1'b0,
   parameter [0:0] CARD_COUNT_M1 = 1'b0,
   parameter [0:0] CARD_ID = 1'b0,
   // Arbitrary revision values
   parameter [3:0] UNIT_REV = 4'h1,
   parameter [3:0] BOARD_REV = 4'h1,
   parameter [3:0] STATION = 4'h0,
   parameter LINE_SHIFT = 6
) (
   input wire clock,
   input wire rst,
   input wire req_valid,
   input wire req_wr,
   input wire [11:0] req_addr,
   input wire req_line_lsb,
   input wire [3:0] req_pid,
   input wire [7:0] req_station,
   input wire [63:0] req_wdata,
   output wire rsp_valid,
   output wire [63:0] rsp_rdata,
   input wire mc_pending,
   input wire mc_cmd_done,
   output wire xfer_valid,
   input wire xfer_ready,
   output wire xfer_part_b,
   output wire [11:0] xfer_cmd,
   output wire [7:0] xfer_rsel,
   output wire [63:0] xfer_data,
   output wire irq_valid,
   input wire irq_ready,
   output wire irq_broadcast,
   output wire [15:0] irq_target,
   output wire [15:0] irq_vector,
   input wire err_valid,
   input wire [11:0] err_cmd,
   input wire [63:0] err_addr,
   input wire [15:0] err_vector,
   input wire mon_irq_req
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_PA = 3'h1;
   localparam [2:0] ST_PB = 3'h2;
   localparam [2:0] ST_P2 = 3'h3;
   localparam [2:0] ST_P3 = 3'h4;

   ////////////////////////////////////////////////////////////////////
   // State
   reg [63:0] ctrl_reg;
   reg [63:0] addr1_reg;
   reg [63:0] addr2_reg;
   reg [63:0] ctgt_reg;
   reg [63:0] mtgt_reg;
   reg [15:0] mon_cfg_reg;
   reg [63:0] err_addr_reg;
   reg [15:0] err_vec_reg;
   reg [11:0] err_cmd_reg;
   reg err_occ_reg;
   reg err_pend_reg;
   reg mon_pend_reg;
   reg lock_reg;
   reg [3:0] own_pid_reg;
   reg [7:0] own_stn_reg;
   reg [2:0] state_reg;
   reg [1:0] phase_reg;
   reg [7:0] cnt_reg;
   reg [7:0] line_reg;
   reg [3:0] svc_reg;
   reg xfer_valid_reg;
   reg xfer_part_b_reg;
   reg [11:0] xfer_cmd_reg;
   reg [63:0] xfer_data_reg;
   reg irq_valid_reg;
   reg irq_bcast_reg;
   reg [15:0] irq_target_reg;
   reg [15:0] irq_vector_reg;
   reg rsp_valid_reg;
   reg [63:0] rsp_rdata_reg;
   reg [63:0] rd_mux;

   ////////////////////////////////////////////////////////////////////
   // Decode
   // card select
   wire hit = req_valid &&
      (CARD_COUNT_M1 == 1'b0 || req_line_lsb == CARD_ID);
   wire rd = hit & ~req_wr;
   wire wr = hit & req_wr;
   wire busy = (state_reg == ST_PA) || (state_reg == ST_PB);
   wire lock_take = rd & (req_addr == `MBFU_OFF_LOCK) & ~lock_reg;
   wire ctrl_wr = wr & (req_addr == `MBFU_OFF_CTRL) & lock_reg &
      (state_reg == ST_IDLE);
   wire ph0 = (phase_reg == `MBFU_PH0);
   wire sf_irq_pend = (state_reg == ST_P2);
   wire any_pend = sf_irq_pend | err_pend_reg | mon_pend_reg;

   function [63:0] mbfu_status;
      input [3:0] pid;
      input [7:0] stn;
      begin
         mbfu_status = {1'b0, err_cmd_reg, sf_irq_pend, phase_reg, stn,
            pid, STATION, BOARD_REV, UNIT_REV, busy, err_occ_reg,
            err_pend_reg, any_pend, CARD_COUNT_M1, LINE_SIZE,
            MODULE_SIZE, mon_cfg_reg};
      end
   endfunction

   always @* begin
      case (req_addr)
         `MBFU_OFF_STATUS: rd_mux = mbfu_status(own_pid_reg, own_stn_reg);
         `MBFU_OFF_LOCK: begin
            if (lock_reg) begin
               rd_mux = mbfu_status(own_pid_reg, own_stn_reg);
            end else begin
               rd_mux = mbfu_status(req_pid, req_station);
            end
         end
         `MBFU_OFF_ERRADR: rd_mux = err_addr_reg;
         `MBFU_OFF_ERRVEC: rd_mux = {48'h000000000000, err_vec_reg};
         `MBFU_OFF_CTGT: rd_mux = ctgt_reg;
         `MBFU_OFF_MTGT: rd_mux = mtgt_reg;
         default: rd_mux = `MBFU_RST_WORD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Part values
   // two commands
   wire [11:0] cmd1 = ctrl_reg[`MBFU_CT_CMD1 +: 12];
   wire [11:0] cmd2 = ctrl_reg[`MBFU_CT_CMD2 +: 12];
   wire [63:0] line_off = {56'h00000000000000, line_reg} << LINE_SHIFT;
   wire a2_cmd = ctrl_reg[`MBFU_CT_A2CMD];
   wire a2_sel = ctrl_reg[`MBFU_CT_A2SEL];
   wire [11:0] a_cmd = (ph0 | ~a2_cmd) ? cmd1 : cmd2;
   wire [63:0] a_base = (ph0 | ~a2_sel) ? addr1_reg : addr2_reg;
   wire [11:0] b_cmd = (ph0 & ~ctrl_reg[`MBFU_CT_B1CMD]) ? cmd1 : cmd2;
   wire [63:0] b_base = (ph0 & ~ctrl_reg[`MBFU_CT_B1SEL]) ?
      addr1_reg : addr2_reg;
   wire b_zero = ph0 ? ctrl_reg[`MBFU_CT_B1ZERO] :
      ctrl_reg[`MBFU_CT_B2ZERO];
   wire b_inc = ph0 ? ctrl_reg[`MBFU_CT_B1INC] : ctrl_reg[`MBFU_CT_B2INC];
   wire [63:0] b_val = (b_zero ? `MBFU_RST_WORD : b_base) +
      (b_inc ? line_off : `MBFU_RST_WORD);
   wire [7:0] cur_count = ph0 ? ctrl_reg[`MBFU_CT_P0CNT +: 8] :
      ctrl_reg[`MBFU_CT_P1CNT +: 8];
   wire last_iter = (cnt_reg == cur_count - 8'h01);
   // wait for idle controller or served quota
   wire go = ~mc_pending | (svc_reg >= `MBFU_SVC_LIMIT);

   ////////////////////////////////////////////////////////////////////
   // Registers and error capture
   // reset state
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `MBFU_RST_WORD;
         addr1_reg <= `MBFU_RST_WORD;
         addr2_reg <= `MBFU_RST_WORD;
         ctgt_reg <= `MBFU_RST_WORD;
         mtgt_reg <= `MBFU_RST_WORD;
         mon_cfg_reg <= `MBFU_RST_CFG;
         err_addr_reg <= `MBFU_RST_WORD;
         err_vec_reg <= 16'h0000;
         err_cmd_reg <= 12'h000;
         err_occ_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_rdata_reg <= `MBFU_RST_WORD;
      end else begin
         rsp_valid_reg <= hit;
         rsp_rdata_reg <= rd ? rd_mux : `MBFU_RST_WORD;
         if (wr) begin
            case (req_addr)
               `MBFU_OFF_STATUS: mon_cfg_reg <= req_wdata[15:0];
               `MBFU_OFF_ADDR1: addr1_reg <= req_wdata;
               `MBFU_OFF_ADDR2: addr2_reg <= req_wdata;
               `MBFU_OFF_CTGT: ctgt_reg <= req_wdata & `MBFU_CTGT_MASK;
               `MBFU_OFF_MTGT: mtgt_reg <= req_wdata & `MBFU_MTGT_MASK;
               default: begin
               end
            endcase
         end
         if (ctrl_wr) begin
            ctrl_reg <= req_wdata;
         end
         // first error kept until its interrupt is sent
         if (err_valid) begin
            err_occ_reg <= 1'b1;
            if (!err_pend_reg) begin
               err_cmd_reg <= err_cmd;
               err_addr_reg <= err_addr;
               err_vec_reg <= err_vector;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         phase_reg <= `MBFU_PH0;
         cnt_reg <= 8'h00;
         line_reg <= 8'h00;
         svc_reg <= 4'h0;
         lock_reg <= 1'b0;
         own_pid_reg <= 4'h0;
         own_stn_reg <= 8'h00;
         err_pend_reg <= 1'b0;
         mon_pend_reg <= 1'b0;
         xfer_valid_reg <= 1'b0;
         xfer_part_b_reg <= 1'b0;
         xfer_cmd_reg <= 12'h000;
         xfer_data_reg <= `MBFU_RST_WORD;
         irq_valid_reg <= 1'b0;
         irq_bcast_reg <= 1'b0;
         irq_target_reg <= 16'h0000;
         irq_vector_reg <= 16'h0000;
      end else begin
         if (lock_take) begin
            lock_reg <= 1'b1;
            own_pid_reg <= req_pid;
            own_stn_reg <= req_station;
         end
         if (mc_cmd_done && svc_reg < `MBFU_SVC_LIMIT) begin
            svc_reg <= svc_reg + 4'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               if (ctrl_wr) begin
                  // entry phase, nonzero taken as 1
                  phase_reg <= (req_wdata[`MBFU_CT_SPH +: 3] == 3'h0) ?
                     `MBFU_PH0 : `MBFU_PH1;
                  cnt_reg <= 8'h00;
                  line_reg <= 8'h00;
                  svc_reg <= 4'h0;
                  state_reg <= ST_PA;
               end else if (err_pend_reg || mon_pend_reg) begin
                  phase_reg <= `MBFU_PH3;
                  state_reg <= ST_P3;
                  irq_valid_reg <= 1'b1;
                  irq_bcast_reg <= err_pend_reg;
                  irq_target_reg <= err_pend_reg ? 16'h0000 :
                     mtgt_reg[`MBFU_TG_TARGET +: 16];
                  irq_vector_reg <= err_pend_reg ? err_vec_reg :
                     mtgt_reg[15:0];
               end
            end
            ST_PA: begin
               if (!xfer_valid_reg) begin
                  if (go) begin
                     xfer_valid_reg <= 1'b1;
                     xfer_part_b_reg <= 1'b0;
                     xfer_cmd_reg <= a_cmd;
                     xfer_data_reg <= a_base + line_off;
                  end
               end else if (xfer_ready) begin
                  xfer_part_b_reg <= 1'b1;
                  xfer_cmd_reg <= b_cmd;
                  xfer_data_reg <= b_val;
                  state_reg <= ST_PB;
               end
            end
            ST_PB: begin
               if (xfer_ready) begin
                  xfer_valid_reg <= 1'b0;
                  xfer_part_b_reg <= 1'b0;
                  svc_reg <= 4'h0;
                  if (!last_iter) begin
                     cnt_reg <= cnt_reg + 8'h01;
                     line_reg <= line_reg + 8'h01;
                     state_reg <= ST_PA;
                  end else if (ph0) begin
                     phase_reg <= `MBFU_PH1;
                     cnt_reg <= 8'h00;
                     line_reg <= 8'h00;
                     state_reg <= ST_PA;
                  end else begin
                     lock_reg <= 1'b0;
                     if (ctgt_reg[`MBFU_TG_TARGET +: 16] != 16'h0000) begin
                        phase_reg <= `MBFU_PH2;
                        state_reg <= ST_P2;
                        irq_valid_reg <= 1'b1;
                        irq_bcast_reg <= 1'b0;
                        irq_target_reg <= ctgt_reg[`MBFU_TG_TARGET +: 16];
                        irq_vector_reg <= ctgt_reg[15:0];
                     end else begin
                        phase_reg <= `MBFU_PH0;
                        state_reg <= ST_IDLE;
                     end
                  end
               end
            end
            ST_P2, ST_P3: begin
               if (irq_ready) begin
                  irq_valid_reg <= 1'b0;
                  phase_reg <= `MBFU_PH0;
                  state_reg <= ST_IDLE;
                  if (state_reg == ST_P3) begin
                     if (irq_bcast_reg) begin
                        err_pend_reg <= 1'b0;
                     end else begin
                        mon_pend_reg <= 1'b0;
                     end
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // Set wins over the clear above
         if (err_valid) begin
            err_pend_reg <= 1'b1;
         end
         if (mon_irq_req) begin
            mon_pend_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign rsp_valid = rsp_valid_reg;
   assign rsp_rdata = rsp_rdata_reg;
   assign xfer_valid = xfer_valid_reg;
   assign xfer_part_b = xfer_part_b_reg;
   assign xfer_cmd = xfer_cmd_reg;
   assign xfer_data = xfer_data_reg;
   assign xfer_rsel = ctrl_reg[`MBFU_CT_RSEL +: 8];
   assign irq_valid = irq_valid_reg;
   assign irq_broadcast = irq_bcast_reg;
   assign irq_target = irq_target_reg;
   assign irq_vector = irq_vector_reg;

endmodule

// ===== common/mbfu_regs.vh
// Purpose: Register offsets, field positions and counts for the block unit
// Assumes: Included by core/mbfu_core.v and the testbench top
// Notes: Offsets are byte offsets within the unit's 4 KB window
`ifndef MBFU_REGS_VH
`define MBFU_REGS_VH
`define MBFU_OFF_STATUS 12'h000
`define MBFU_OFF_CTRL 12'h100
`define MBFU_OFF_ADDR1 12'h200
`define MBFU_OFF_ADDR2 12'h300
`define MBFU_OFF_ERRADR 12'h400
`define MBFU_OFF_ERRVEC 12'h500
`define MBFU_OFF_CTGT 12'h600
`define MBFU_OFF_MTGT 12'h700
`define MBFU_OFF_LOCK 12'h800
`define MBFU_CT_P0CNT 0
`define MBFU_CT_P1CNT 8
`define MBFU_CT_RSEL 16
`define MBFU_CT_SPH 24
`define MBFU_CT_CMD1 32
`define MBFU_CT_B1INC 44
`define MBFU_CT_B1ZERO 45
`define MBFU_CT_B1SEL 46
`define MBFU_CT_B1CMD 47
`define MBFU_CT_CMD2 48
`define MBFU_CT_B2INC 60
`define MBFU_CT_B2ZERO 61
`define MBFU_CT_A2SEL 62
`define MBFU_CT_A2CMD 63
`define MBFU_TG_TARGET 32
`define MBFU_CTGT_MASK 64'hFFFFFFFF0000FFFF
`define MBFU_MTGT_MASK 64'h0000FFFF0000FFFF
`define MBFU_RST_WORD 64'h0000000000000000
`define MBFU_RST_CFG 16'h0000
`define MBFU_SVC_LIMIT 4'h8
`define MBFU_PH0 2'h0
`define MBFU_PH1 2'h1
`define MBFU_PH2 2'h2
`define MBFU_PH3 2'h3
`endif

// ===== testbench/mbfu_bus_partner.sv
// Purpose: Station bus side that takes parts and interrupts
// Assumes: Offers arrive registered from the unit
// Notes: Stall delays every part take, a slow bus is normal
`timescale 1ns/1ps
module mbfu_bus_partner (
   input wire clock,
   input wire [3:0] stall,
   input wire xfer_valid,
   output logic xfer_ready,
   input wire xfer_part_b,
   input wire [11:0] xfer_cmd,
   input wire [63:0] xfer_data,
   input wire irq_valid,
   output logic irq_ready,
   input wire irq_broadcast,
   input wire [15:0] irq_target,
   input wire [15:0] irq_vector
);
   int wait_cnt = 0;
   // Interrupts taken a cycle late so a held offer is seen
   bit irq_seen = 0;
   logic [76:0] part_q[$];
   logic [76:0] irq_q[$];
   initial begin
      xfer_ready = 0;
      irq_ready = 0;
   end
   ////////////////////////////////////////
   always @(posedge clock) begin
      if (xfer_valid && xfer_ready) begin
         part_q.push_back({xfer_part_b, xfer_cmd, xfer_data});
         wait_cnt = 0;
      end else if (xfer_valid)
         wait_cnt++;
      if (irq_valid && irq_ready)
         irq_q.push_back({irq_broadcast, irq_target, irq_vector});
      irq_seen = irq_valid && !irq_ready;
      #1;
      // Ready only after the offer is seen, never ahead of it
      xfer_ready = xfer_valid && wait_cnt >= stall;
      irq_ready = irq_valid && irq_seen;
   end
endmodule

// ===== testbench/mbfu_core_asserts.sv
// Purpose: Port checks for the block unit
// Assumes: One card clock, card select not used
// Notes: Bound into every unit instance
`timescale 1ns/1ps
module mbfu_chk (
   input wire clock,
   input wire rst,
   input wire req_valid,
   input wire req_wr,
   input wire [11:0] req_addr,
   input wire rsp_valid,
   input wire [63:0] rsp_rdata,
   input wire mc_pending,
   input wire mc_cmd_done,
   input wire xfer_valid,
   input wire xfer_ready,
   input wire xfer_part_b,
   input wire [63:0] xfer_data,
   input wire irq_valid,
   input wire irq_ready,
   input wire [15:0] irq_vector
);
   reg [3:0] done_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Served commands since the last iteration; saturates
   always @(posedge clock or posedge rst) begin
      if (rst)
         done_reg <= 4'h0;
      else if (xfer_valid && xfer_ready && xfer_part_b)
         done_reg <= 4'h0;
      else if (mc_cmd_done && done_reg != 4'hF)
         done_reg <= done_reg + 4'h1;
   end
   ////////////////////////////////////////
   rsp_answers_a:
      assert property (req_valid |=> rsp_valid)
      else $error("request not answered");
   rsp_no_extra_a:
      assert property (rsp_valid |-> $past(req_valid))
      else $error("answer without request");
   ctrl_wo_a:
      assert property (req_valid && req_wr && req_addr == 12'h100
         |=> rsp_rdata == 64'h0)
      else $error("control write returned data");
   part_b_next_a:
      assert property (xfer_valid && xfer_ready && !xfer_part_b
         |=> xfer_valid && xfer_part_b)
      else $error("second part missing");
   xfer_hold_a:
      assert property (xfer_valid && !xfer_ready |=> xfer_valid
         && $stable(xfer_data) && $stable(xfer_part_b))
      else $error("part changed before taken");
   iter_pace_a:
      assert property ($rose(xfer_valid) && !xfer_part_b
         && $past(mc_pending) && $past(mc_pending, 2)
         |-> $past(done_reg) >= 4'h8)
      else $error("iteration advanced while busy");
   irq_hold_a:
      assert property (irq_valid && !irq_ready
         |=> irq_valid && $stable(irq_vector))
      else $error("interrupt dropped before taken");
   irq_drop_a:
      assert property (irq_valid && irq_ready |=> !irq_valid)
      else $error("interrupt offered twice");
   reset_quiet_a:
      assert property ($fell(rst) |-> !xfer_valid && !irq_valid
         && !rsp_valid)
      else $error("activity right after reset");
   cover property (xfer_valid && xfer_ready && xfer_part_b);
   cover property (irq_valid && irq_ready);
   cover property (req_valid && !req_wr && req_addr == 12'h800);
endmodule
////////////////////////////////////////
bind mbfu_core mbfu_chk u_chk (.clock(clock), .rst(rst),
   .req_valid(req_valid), .req_wr(req_wr), .req_addr(req_addr),
   .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
   .mc_pending(mc_pending), .mc_cmd_done(mc_cmd_done),
   .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
   .xfer_part_b(xfer_part_b), .xfer_data(xfer_data),
   .irq_valid(irq_valid), .irq_ready(irq_ready),
   .irq_vector(irq_vector));

// ===== testbench/memory_block_function_unit_tb_top.sv
// Purpose: Self-checking bench for the block unit
// Assumes: One card, card select tied
// Notes: Counts kept small so the run stays short
`timescale 1ns/1ps
`include "mbfu_regs.vh"
module memory_block_function_unit_tb_top;
   reg clock, rst, req_valid, req_wr, mc_pending, mc_cmd_done;
   reg err_valid, mon_irq_req;
   reg [11:0] req_addr, err_cmd;
   reg [3:0] req_pid, stall;
   reg [7:0] req_station;
   reg [63:0] req_wdata, err_addr, rd;
   reg [15:0] err_vector;
   wire rsp_valid, xfer_valid, xfer_ready, xfer_part_b;
   wire irq_valid, irq_ready, irq_broadcast;
   wire [63:0] rsp_rdata, xfer_data;
   wire [11:0] xfer_cmd;
   wire [7:0] xfer_rsel;
   wire [15:0] irq_target, irq_vector;
   int miscompares, cmp_count, cyc, i;
   mbfu_core #(.MODULE_SIZE(2'h2), .UNIT_REV(4'h5), .BOARD_REV(4'hA),
      .STATION(4'h3)) dut (.clock(clock), .rst(rst),
      .req_valid(req_valid), .req_wr(req_wr), .req_addr(req_addr),
      .req_line_lsb(1'h0), .req_pid(req_pid), .req_station(req_station),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .mc_pending(mc_pending), .mc_cmd_done(mc_cmd_done),
      .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
      .xfer_part_b(xfer_part_b), .xfer_cmd(xfer_cmd),
      .xfer_rsel(xfer_rsel), .xfer_data(xfer_data),
      .irq_valid(irq_valid), .irq_ready(irq_ready),
      .irq_broadcast(irq_broadcast), .irq_target(irq_target),
      .irq_vector(irq_vector), .err_valid(err_valid), .err_cmd(err_cmd),
      .err_addr(err_addr), .err_vector(err_vector),
      .mon_irq_req(mon_irq_req));
   mbfu_bus_partner u_bus (.clock(clock), .stall(stall),
      .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
      .xfer_part_b(xfer_part_b), .xfer_cmd(xfer_cmd),
      .xfer_data(xfer_data), .irq_valid(irq_valid),
      .irq_ready(irq_ready), .irq_broadcast(irq_broadcast),
      .irq_target(irq_target), .irq_vector(irq_vector));
   ////////////////////////////////////////
   task chk(input [76:0] got, input [76:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask
   task acc(input w, input [11:0] a, input [63:0] d);
      @(posedge clock);
      #1;
      {req_valid, req_wr, req_addr, req_wdata} = {1'h1, w, a, d};
      @(posedge clock);
      #1;
      req_valid = 0;
      rd = rsp_rdata;
      chk(rsp_valid, 1, "no answer");
   endtask
   task cyc_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wait_irq(input int n);
      repeat (400) if (u_bus.irq_q.size() < n) @(posedge clock);
      #1;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////
   task t_reset;
      acc(0, 12'h000, 64'h0);
      chk(rd[19:16], 4'h2, "sizes");
      chk(rd[35:24], 12'h3A5, "revisions");
      chk({rd[50:48], rd[23:20]}, 7'h0, "idle flags");
      $display("test reset done");
   endtask
   task t_lock;
      acc(1, 12'h100, 64'h0000_0000_0100_0100);
      cyc_n(6);
      chk(u_bus.part_q.size(), 0, "start unlocked");
      {req_pid, req_station} = 12'h621;
      acc(0, 12'h800, 64'h0);
      chk(rd[47:36], 12'h216, "owner");
      rd = rd;
      acc(0, 12'h000, 64'h0);
      chk(rd[47:36], 12'h216, "status owner");
      acc(1, 12'h600, 64'hFFFF_FFFF_FFFF_FFFF);
      acc(0, 12'h600, 64'h0);
      chk(rd, `MBFU_CTGT_MASK, "target");
      acc(1, 12'h400, 64'hFFFF_FFFF_FFFF_FFFF);
      acc(0, 12'h400, 64'h0);
      chk(rd, 0, "read only");
      acc(0, 12'h900, 64'h0);
      chk(rd, 0, "unmapped");
      chk(u_bus.part_q.size(), 0, "setup started");
      {req_pid, req_station} = 12'h940;
      acc(0, 12'h800, 64'h0);
      chk(rd[47:36], 12'h216, "lock kept");
      $display("test lock done");
   endtask
   task t_run;
      stall = 4'h2;
      acc(1, 12'h200, 64'h1000);
      acc(1, 12'h300, 64'h8000);
      acc(1, 12'h600, 64'h0000_8102_0000_BEEF);
      acc(1, 12'h100, 64'h22C3_B1A5_005A_0302);
      acc(0, 12'h000, 64'h0);
      chk({rd[49:48], rd[23]}, 3'h1, "running");
      chk(xfer_rsel, 8'h5A, "response select");
      acc(1, 12'h100, 64'h0000_0000_0001_0001);
      wait_irq(1);
      chk(u_bus.part_q.size(), 10, "parts");
      for (i = 0; i < 5; i++) begin
         chk(u_bus.part_q[2 * i], {13'h1A5,
            64'h1000 + 64 * (i < 2 ? i : i - 2)}, "part A");
         // Phase 0 sets zero and increment: line step from zero; phase 1 zero only
         chk(u_bus.part_q[2 * i + 1], {13'h12C3, i < 2 ?
            64'h0 + 64 * i : 64'h0}, "part B");
      end
      chk(u_bus.irq_q[0], {17'h08102, 16'hBEEF}, "done irq");
      {req_pid, req_station} = 12'h310;
      acc(0, 12'h800, 64'h0);
      chk(rd[47:36], 12'h103, "relock");
      $display("test run done");
   endtask
   task t_pace;
      stall = 4'h0;
      u_bus.part_q.delete();
      mc_pending = 1;
      acc(1, 12'h100, 64'h0000_0000_0100_0200);
      cyc_n(8);
      repeat (7) begin
         @(posedge clock);
         #1 mc_cmd_done = 1;
         @(posedge clock);
         #1 mc_cmd_done = 0;
      end
      cyc_n(4);
      chk(u_bus.part_q.size(), 0, "advanced early");
      @(posedge clock);
      #1 mc_cmd_done = 1;
      @(posedge clock);
      #1 mc_cmd_done = 0;
      cyc_n(6);
      chk(u_bus.part_q.size(), 2, "one iteration");
      mc_pending = 0;
      wait_irq(2);
      chk(u_bus.part_q.size(), 4, "all iterations");
      $display("test pace done");
   endtask
   task t_err;
      {err_cmd, err_addr, err_vector} = {12'hABC, 64'h1234_5678, 16'h1234};
      @(posedge clock);
      #1 err_valid = 1;
      @(posedge clock);
      #1 err_valid = 0;
      wait_irq(3);
      chk(u_bus.irq_q[2], {17'h10000, 16'h1234}, "error irq");
      acc(0, 12'h400, 64'h0);
      chk(rd, 64'h1234_5678, "error address");
      acc(0, 12'h500, 64'h0);
      chk(rd[15:0], 16'h1234, "error vector");
      acc(1, 12'h700, 64'h0000_4411_0000_7788);
      @(posedge clock);
      #1 mon_irq_req = 1;
      @(posedge clock);
      #1 mon_irq_req = 0;
      wait_irq(4);
      chk(u_bus.irq_q[3], {17'h04411, 16'h7788}, "monitor irq");
      acc(0, 12'h000, 64'h0);
      chk({rd[50], rd[22:20]}, 4'h4, "flags");
      $display("test error done");
   endtask
   ////////////////////////////////////////
   always @(posedge clock) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   initial begin
      rst = 1;
      {req_valid, req_wr, mc_pending, mc_cmd_done} = 4'h0;
      {err_valid, mon_irq_req, err_vector} = 18'h0;
      {req_addr, err_cmd, req_pid, stall, req_station} = 40'h0;
      {req_wdata, err_addr} = 128'h0;
      repeat (3) @(posedge clock);
      #1 rst = 0;
      t_reset();
      t_lock();
      t_run();
      t_pace();
      t_err();
      give_verdict();
   end
endmodule
